/* File: rtl/eoc_pkg.sv */
// Package for the external oscillator control block: register map,
// field layout, mode codes, pin indices and stability timing.
// Assumes the core register port addresses by 8-bit index.
package eoc_pkg;
    localparam logic [7:0] EOC_CTRL_ADDR = 8'hB1;
    localparam logic [7:0] EOC_CTRL_RESET = 8'h00;
    localparam int EOC_VALID_BIT = 7;
    localparam int EOC_MODE_LSB = 4;
    localparam int EOC_MODE_MSB = 6;
    localparam int EOC_FREQ_LSB = 0;
    localparam int EOC_FREQ_MSB = 2;
    localparam logic [7:0] EOC_WRITE_MASK = 8'h77;
    // Mode field codes
    localparam logic [2:0] EOC_MODE_OFF0 = 3'h0;
    localparam logic [2:0] EOC_MODE_OFF1 = 3'h1;
    localparam logic [2:0] EOC_MODE_CMOS = 3'h2;
    localparam logic [2:0] EOC_MODE_CMOS_DIV2 = 3'h3;
    localparam logic [2:0] EOC_MODE_RC_DIV2 = 3'h4;
    localparam logic [2:0] EOC_MODE_CAP_DIV2 = 3'h5;
    localparam logic [2:0] EOC_MODE_XTAL = 3'h6;
    localparam logic [2:0] EOC_MODE_XTAL_DIV2 = 3'h7;
    // Port 0 pin positions taken by the oscillator
    localparam int EOC_PIN_XIN = 2;
    localparam int EOC_PIN_XOUT = 3;
    // Oscillator edges seen before the source counts as stable
    localparam int EOC_STABLE_EDGES = 1024;
    localparam int EOC_SYNC_STAGES = 3;

    typedef struct packed {
        logic valid;
        logic [2:0] mode;
        logic rsvd;
        logic [2:0] freq;
    } eoc_ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } eoc_reg_req_s;

    typedef struct packed {
        logic xin_claim;
        logic xout_claim;
    } eoc_pin_claim_s;
endpackage

/* File: rtl/eoc_pin_sync.sv */
// Three-stage synchroniser with agreement filter for an oscillator pin.
// Assumes the pin is asynchronous to ref_clk_in.
`timescale 1ns/1ps
module eoc_pin_sync (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out
);
    import eoc_pkg::*;
    logic [EOC_SYNC_STAGES-1:0] sync_q;
    logic level_q;
    wire agree = (sync_q[1] == sync_q[2]);
    wire level_d = agree ? sync_q[2] : level_q;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_q <= '0;
            level_q <= 1'b0;
            rise_out <= 1'b0;
        end else begin
            sync_q <= {sync_q[EOC_SYNC_STAGES-2:0], pin_in};
            level_q <= level_d;
            rise_out <= level_d & ~level_q;
        end
    end

    assign level_out = level_q;
endmodule

/* File: rtl/eoc_ctrl.sv */
// External oscillator control: mode register, pin claiming, crystal
// valid detection and the derived clock offered to the clock tree.
// Assumes the core register port is synchronous to ref_clk_in and that
// the oscillator pin toggles well below half the core rate.
// Only the crystal output pin is watched; the crystal input pin is
// claimed for the analog circuit and never read here. The derived
// clock is a resampled level, not a glitch-free clock for a mux.
`timescale 1ns/1ps
module eoc_ctrl #(
    parameter int STABLE_EDGES = eoc_pkg::EOC_STABLE_EDGES
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire eoc_pkg::eoc_reg_req_s reg_req_in,
    output logic [7:0] reg_rdata_out,
    input wire logic osc_pin_in,
    output eoc_pkg::eoc_pin_claim_s pin_claim_out,
    output logic [2:0] freq_range_out,
    output logic drive_en_out,
    output logic osc_clk_out,
    output logic osc_tick_out,
    output logic clk_src_ok_out
);
    import eoc_pkg::*;

    localparam int CW = $clog2(STABLE_EDGES + 1);
    localparam logic [CW-1:0] STABLE_LAST = CW'(STABLE_EDGES - 1);

    eoc_ctrl_s ctrl_q;
    logic [CW-1:0] stab_cnt_q;
    logic stable_q;
    logic half_q;
    logic level_sync;
    logic rise_sync;

    function automatic logic mode_enabled(input logic [2:0] m);
        return (m != EOC_MODE_OFF0) && (m != EOC_MODE_OFF1);
    endfunction

    function automatic logic mode_is_cmos(input logic [2:0] m);
        return (m == EOC_MODE_CMOS) || (m == EOC_MODE_CMOS_DIV2);
    endfunction

    function automatic logic mode_is_xtal(input logic [2:0] m);
        return (m == EOC_MODE_XTAL) || (m == EOC_MODE_XTAL_DIV2);
    endfunction

    function automatic logic mode_div2(input logic [2:0] m);
        return mode_enabled(m) && (m != EOC_MODE_CMOS)
            && (m != EOC_MODE_XTAL);
    endfunction

    eoc_pin_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .pin_in(osc_pin_in),
        .level_out(level_sync),
        .rise_out(rise_sync)
    );

    wire [2:0] mode = ctrl_q.mode;
    wire enabled = mode_enabled(mode);
    wire is_cmos = mode_is_cmos(mode);
    wire is_xtal = mode_is_xtal(mode);
    wire div2 = mode_div2(mode);
    wire hit = (reg_req_in.addr == EOC_CTRL_ADDR);
    wire wr_hit = reg_req_in.wr & hit;
    wire rd_hit = reg_req_in.rd & hit;
    wire [7:0] wr_val = reg_req_in.wdata & EOC_WRITE_MASK;
    wire [2:0] wr_mode = wr_val[EOC_MODE_MSB:EOC_MODE_LSB];
    wire mode_change = wr_hit && (wr_mode != mode);
    wire stab_done = (stab_cnt_q == STABLE_LAST);
    // Restart detection whenever the source is changed or stopped
    wire stab_clear = mode_change | ~enabled;
    wire stab_step = rise_sync & ~stab_done;
    wire stab_hit = rise_sync & stab_done;
    // Clear beats a coincident edge: the old source says nothing new
    wire [CW-1:0] stab_cnt_d = stab_clear ? '0 :
        stab_step ? stab_cnt_q + CW'(1) : stab_cnt_q;
    wire stable_d = stab_clear ? 1'b0 : (stable_q | stab_hit);
    wire valid_bit = stable_q & enabled & ~is_cmos;

    eoc_ctrl_s rd_view;
    always_comb begin
        rd_view = ctrl_q;
        rd_view.valid = valid_bit;
        rd_view.rsvd = 1'b0;
    end

    wire [7:0] rdata_d = rd_hit ? rd_view : reg_rdata_out;
    // Halving toggles on each rising oscillator edge: even duty
    wire half_d = (!enabled) ? 1'b0 : (rise_sync ? ~half_q : half_q);
    wire clk_d = !enabled ? 1'b0 : (div2 ? half_q : level_sync);
    wire tick_d = enabled & rise_sync & (!div2 | half_q);
    // CMOS sources have no detector, so they count as usable at once
    wire src_ok_d = enabled & (is_cmos | stable_q);

    // Control register; bit 7 and bit 3 are never stored
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_q <= EOC_CTRL_RESET;
        end else if (wr_hit) begin
            ctrl_q <= wr_val;
        end
    end

    // Counter saturates so a long run never wraps back to unstable
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stab_cnt_q <= '0;
        end else begin
            stab_cnt_q <= stab_cnt_d;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stable_q <= 1'b0;
        end else begin
            stable_q <= stable_d;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            half_q <= 1'b0;
        end else begin
            half_q <= half_d;
        end
    end

    // Read data holds between reads so a slow poll sees a steady value
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= EOC_CTRL_RESET;
        end else begin
            reg_rdata_out <= rdata_d;
        end
    end

    // Claims follow the stored mode one edge after the register
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_claim_out <= '0;
        end else begin
            pin_claim_out.xin_claim <= enabled & is_xtal;
            pin_claim_out.xout_claim <= enabled;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            freq_range_out <= '0;
        end else begin
            freq_range_out <= ctrl_q.freq;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            drive_en_out <= 1'b0;
        end else begin
            drive_en_out <= enabled;
        end
    end

    // Resampled, so the derived clock lags the pin by five core cycles, six when halved
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            osc_clk_out <= 1'b0;
        end else begin
            osc_clk_out <= clk_d;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            osc_tick_out <= 1'b0;
        end else begin
            osc_tick_out <= tick_d;
        end
    end

    // Clock switching logic gates on this, not on the valid bit
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            clk_src_ok_out <= 1'b0;
        end else begin
            clk_src_ok_out <= src_ok_d;
        end
    end
endmodule

/* File: sim/eoc_assertions.sv */
// Port checker for the oscillator control block.
// Assumes reads come at least two cycles after any write.
`timescale 1ns/1ps
module eoc_assertions
    import eoc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire eoc_pkg::eoc_reg_req_s reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire eoc_pkg::eoc_pin_claim_s pin_claim_out,
    input wire logic [2:0] freq_range_out,
    input wire logic drive_en_out,
    input wire logic osc_tick_out,
    input wire logic clk_src_ok_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    wire logic rd_hit = reg_req_in.rd && reg_req_in.addr == EOC_CTRL_ADDR;
    wire logic wr_hit = reg_req_in.wr && reg_req_in.addr == EOC_CTRL_ADDR;
    // Settled read: register and outputs agree
    sequence quiet_rd_s;
        rd_hit && !$past(wr_hit) && !$past(wr_hit, 2);
    endsequence
    xout_claim_a: assert property (pin_claim_out.xout_claim == drive_en_out)
        else $error("xout claim differs from drive");
    xin_mode_a: assert property (quiet_rd_s |=> pin_claim_out.xin_claim ==
        (reg_rdata_out[6:5] == 2'b11)) else $error("xin claim wrong");
    drive_mode_a: assert property (quiet_rd_s |=> drive_en_out ==
        (reg_rdata_out[6:5] != 2'b00)) else $error("drive enable wrong");
    freq_copy_a: assert property (quiet_rd_s |=>
        reg_rdata_out[2:0] == freq_range_out) else $error("freq copy wrong");
    valid_mode_a: assert property (reg_rdata_out[7] |-> reg_rdata_out[6])
        else $error("valid set in cmos or off mode");
    valid_src_a: assert property (quiet_rd_s ##1 reg_rdata_out[7]
        |-> clk_src_ok_out) else $error("valid without usable source");
    rd_hold_a: assert property (!rd_hit |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    tick_pulse_a: assert property (osc_tick_out |=> !osc_tick_out)
        else $error("tick longer than one cycle");
    src_off_a: assert property (!drive_en_out [*2] |-> !clk_src_ok_out)
        else $error("source ok while drive off");
endmodule

bind eoc_ctrl eoc_assertions u_chk (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .pin_claim_out(pin_claim_out),
    .freq_range_out(freq_range_out), .drive_en_out(drive_en_out),
    .osc_tick_out(osc_tick_out), .clk_src_ok_out(clk_src_ok_out));

/* File: sim/eoc_osc_model.sv */
// Behavioural oscillator on the crystal output pin.
// Assumes run_in follows the drive enable; pin rests low when stopped.
`timescale 1ns/1ps
module eoc_osc_model #(
    parameter int HALF_NS = 67
) (
    input wire logic run_in,
    output logic pin_out
);
    // Odd half period keeps three of every four pin edges off the core clock edges
    // Only the output pin is modelled; software skips and sets up pins
    initial begin
        pin_out = 1'b0;
        forever begin
            #(HALF_NS);
            pin_out = run_in ? ~pin_out : 1'b0;
        end
    end
endmodule

/* File: sim/tb_top.sv */
// Bench: register tasks, mode sweep, stability and tick counts.
// Assumes the oscillator model runs only while the drive is enabled.
`timescale 1ns/1ps
module tb_top;
    import eoc_pkg::*;
    `define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
        n_fail++; $display("wrong value %s exp %0h got %0h", nm, e, g); \
        end end
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    eoc_reg_req_s req = '0;
    eoc_pin_claim_s claim;
    logic [7:0] rdata;
    logic [2:0] freq;
    logic pin, drive, tick, src_ok, oclk;
    logic [2:0] modes [4] = '{EOC_MODE_CMOS, EOC_MODE_CMOS_DIV2,
        EOC_MODE_XTAL, EOC_MODE_XTAL_DIV2};
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int ticks;
    int hi;
    eoc_ctrl #(.STABLE_EDGES(4)) DUT (.ref_clk_in(ref_clk_in),
        .reset_in(reset_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .osc_pin_in(pin), .pin_claim_out(claim), .freq_range_out(freq),
        .drive_en_out(drive), .osc_clk_out(oclk), .osc_tick_out(tick),
        .clk_src_ok_out(src_ok));
    eoc_osc_model u_osc (.run_in(drive), .pin_out(pin));
    initial forever #4 ref_clk_in = ~ref_clk_in;
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge ref_clk_in);
        req <= '0;
        @(negedge ref_clk_in);
        if (w) repeat (4) @(posedge ref_clk_in);
        else `CHK("rdata", d, rdata)
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        acc(1'b0, 8'hB1, 8'h00);
        for (int m = 0; m < 8; m++) begin
            acc(1'b1, 8'hB1, {1'b1, 3'(m), 1'b1, 3'(m)});
            `CHK("xin", m >= 6, claim.xin_claim)
            `CHK("xout", m >= 2, claim.xout_claim)
            `CHK("freq", 3'(m), freq)
            acc(1'b0, 8'hB1, {1'b0, 3'(m), 1'b0, 3'(m)});
        end
        $display("mode sweep done");
        foreach (modes[i]) begin
            acc(1'b1, 8'hB1, {1'b0, modes[i], 4'h0});
            repeat (150) @(posedge ref_clk_in);
            acc(1'b0, 8'hB1, {modes[i][2], modes[i], 4'h0});
            `CHK("src_ok", 1'b1, src_ok)
            ticks = 0;
            hi = 0;
            repeat (320) @(posedge ref_clk_in) begin
                ticks += tick;
                hi += oclk;
            end
            `CHK("duty", 1'b1, hi >= 140 && hi <= 180)
            ticks = ticks * (modes[i][0] ? 2 : 1);
            `CHK("ticks", 1'b1, ticks >= 18 && ticks <= 22)
        end
        $display("stability done");
        acc(1'b0, 8'hB0, 8'hF0);
        acc(1'b1, 8'hB0, 8'h00);
        `CHK("drive", 1'b1, drive)
        acc(1'b1, 8'hB1, 8'h10);
        `CHK("drive", 1'b0, drive)
        `CHK("src_ok", 1'b0, src_ok)
        acc(1'b0, 8'hB1, 8'h10);
        $display("unmapped and off done");
        final_report();
    end
endmodule
